// >>> pcs_pkg.sv
/*
 pcs_pkg: constants, register offsets, types for the pc/stack/indirect unit.
 assumes: included before every design file of the unit.
*/
`default_nettype none
package pcs_pkg;
	// ----------------------------------------------------------------
	// widths and stack
	// ----------------------------------------------------------------
	localparam int PCS_PC_W    = 15;
	localparam int PCS_DEPTH   = 16;
	localparam int PCS_SP_W    = 5;
	localparam logic [4:0]  PCS_SP_RESET = 5'h1F;
	localparam logic [14:0] PCS_PC_RESET = 15'h0000;
	localparam logic [14:0] PCS_PC_ONE   = 15'h0001;
	// ----------------------------------------------------------------
	// axi register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] PCS_OFS_TOP_LOW  = 8'h00;
	localparam logic [7:0] PCS_OFS_TOP_HIGH = 8'h04;
	localparam logic [7:0] PCS_OFS_INDEX    = 8'h08;
	localparam logic [7:0] PCS_OFS_CONTROL  = 8'h0C;
	localparam logic [7:0] PCS_OFS_STATUS   = 8'h10;
	localparam logic [7:0] PCS_OFS_PC       = 8'h14;
	localparam logic [7:0] PCS_OFS_PAGE     = 8'h18;
	localparam int PCS_CTL_SRE_BIT  = 0;
	localparam int PCS_STS_OVF_BIT  = 0;
	localparam int PCS_STS_UNF_BIT  = 1;
	localparam logic [1:0] PCS_RESP_OKAY   = 2'h0;
	localparam logic [1:0] PCS_RESP_SLVERR = 2'h2;
	// ----------------------------------------------------------------
	// indirect address map
	// ----------------------------------------------------------------
	localparam logic [15:0] PCS_TRAD_LAST   = 16'h0FFF;
	localparam logic [15:0] PCS_LIN_FIRST   = 16'h2000;
	localparam logic [15:0] PCS_LIN_LAST    = 16'h29AF;
	localparam logic [7:0]  PCS_EE_HIGH     = 8'h70;
	localparam logic [6:0]  PCS_RAM_BYTES   = 7'h50;
	localparam logic [6:0]  PCS_RAM_BASE    = 7'h20;
	localparam logic [6:0]  PCS_BANK_MASK   = 7'h7F;
	localparam logic [6:0]  PCS_PORT0_OFS   = 7'h00;
	localparam logic [6:0]  PCS_PORT1_OFS   = 7'h01;
	localparam logic [7:0]  PCS_ZERO_BYTE   = 8'h00;

	typedef enum logic [2:0] {
		PCS_OP_NONE   = 3'h0,
		PCS_OP_CALL   = 3'h1,
		PCS_OP_CALL_COMPUTED = 3'h2,
		PCS_OP_ACC_BRANCH    = 3'h3,
		PCS_OP_IMM_JUMP      = 3'h4,
		PCS_OP_INT    = 3'h5,
		PCS_OP_RET    = 3'h6,
		PCS_OP_PCLWR  = 3'h7
	} pcs_op_type;

	typedef enum logic [2:0] {
		PCS_REG_TRAD  = 3'h0,
		PCS_REG_LIN   = 3'h1,
		PCS_REG_EE    = 3'h2,
		PCS_REG_FLASH = 3'h3,
		PCS_REG_SELF  = 3'h4,
		PCS_REG_NONE  = 3'h5
	} pcs_region_type;

	// decoded indirect access toward the memories
	typedef struct packed {
		pcs_region_type region;
		logic [15:0]    addr;
		logic           wr_allow;
		logic           extra_cycle;
	} pcs_ind_type;
endpackage
`default_nettype wire

// >>> pcs_ind_decode.sv
/*
 pcs_ind_decode: maps a 16-bit indirect pointer to a memory region.
 assumes: combinational use by the core's operand sequencer.
*/
`timescale 1ns/1ps
`default_nettype none
module pcs_ind_decode
	import pcs_pkg::*;
(
	input  wire logic [15:0] pointer,
	output pcs_ind_type      dec
);
	logic [15:0] lin_ofs;
	logic [6:0]  bank;
	logic [6:0]  inbank;
	logic [13:0] lin_abs;

	// ------------------------------------------------------------
	// linear view: 80-byte ram slices of successive banks
	// ------------------------------------------------------------
	always_comb begin
		lin_ofs = pointer - PCS_LIN_FIRST;
		bank    = 7'(lin_ofs / 16'(PCS_RAM_BYTES));
		inbank  = 7'(lin_ofs % 16'(PCS_RAM_BYTES));
		lin_abs = {bank, PCS_RAM_BASE + inbank};
	end

	// region select in priority order
	always_comb begin
		dec.addr        = pointer;
		dec.wr_allow    = 1'b0;
		dec.extra_cycle = 1'b0;
		dec.region      = PCS_REG_NONE;
		if (pointer[15]) begin
			dec.region      = PCS_REG_FLASH;
			dec.addr        = {1'b0, pointer[14:0]};
			dec.extra_cycle = 1'b1;
		end else if (pointer[15:8] == PCS_EE_HIGH) begin
			dec.region      = PCS_REG_EE;
			dec.addr        = {8'h00, pointer[7:0]};
			dec.extra_cycle = 1'b1;
		end else if (pointer <= PCS_TRAD_LAST) begin
			if ((pointer[6:0] & PCS_BANK_MASK) == PCS_PORT0_OFS ||
			    pointer[6:0] == PCS_PORT1_OFS) begin
				dec.region = PCS_REG_SELF;
			end else begin
				dec.region   = PCS_REG_TRAD;
				dec.wr_allow = 1'b1;
			end
		end else if (pointer >= PCS_LIN_FIRST && pointer <= PCS_LIN_LAST) begin
			dec.region   = PCS_REG_LIN;
			dec.addr     = {2'b00, lin_abs};
			dec.wr_allow = 1'b1;
		end
	end
endmodule
`default_nettype wire

// >>> pcs_core.sv
/*
 pcs_core: program counter loader, 16-entry return stack and indirect
 port front end, with an axi4-lite register slave.
 assumes: one clock aclk at 10 MHz; the sequencer gives one op per cycle
 and memories answer reads within one cycle of mem_rd.
*/
// Behaviour
// - call loads pc from operand and latch
// - computed call: low from acc, high latch
// - acc branch: pc plus one plus acc
// - imm branch: pc plus one plus signed
// - sixteen entry fifteen bit return stack
// - push on calls, pop on returns
// - stack wraps when reset disabled
// - overflow and underflow flags always set
// - stack fault resets when reset enabled
// - five bit index, readable top pair
// - push bumps then writes; pop reads then drops
// - indirect port acts at pointer address
// - pointer at port: read zero, no write
// - low 4k maps to absolute addresses
// - linear region chains bank ram blocks
// - unimplemented linear reads give zero
// - common memory outside linear region
// - 0x70 page reads eeprom, no writes
// - eeprom read adds one cycle
// - flash high half, low byte, no writes
// - flash read adds one cycle
// - reset clears program counter
// - low byte write loads latch high
`timescale 1ns/1ps
`default_nettype none
module pcs_core
	import pcs_pkg::*;
#(
	parameter int DEPTH = PCS_DEPTH
)(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// sequencer side
	input  wire pcs_op_type  op,
	input  wire logic [10:0] operand,
	input  wire logic [7:0]  acc,
	input  wire logic [6:0]  page_latch,
	input  wire logic [7:0]  pc_low_wdata,
	input  wire logic        stack_reset_enable,
	output logic [14:0]      pc_ff,
	output logic [14:0]      return_pc,
	output logic             stack_fault_reset,
	// indirect port side
	input  wire logic        ind_req,
	input  wire logic        ind_we,
	input  wire logic [15:0] pointer,
	input  wire logic [7:0]  ind_wdata,
	output logic             ind_stall,
	output logic             mem_rd,
	output logic             mem_wr,
	output pcs_ind_type      mem_sel,
	input  wire logic [7:0]  mem_rdata,
	input  wire logic [13:0] flash_rdata,
	input  wire logic        mem_implemented,
	output logic [7:0]       ind_rdata_ff,
	// axi4-lite slave
	input  wire logic [7:0]  s_awaddr,
	input  wire logic        s_awvalid,
	output logic             s_awready,
	input  wire logic [31:0] s_wdata,
	input  wire logic [3:0]  s_wstrb,
	input  wire logic        s_wvalid,
	output logic             s_wready,
	output logic [1:0]       s_bresp,
	output logic             s_bvalid,
	input  wire logic        s_bready,
	input  wire logic [7:0]  s_araddr,
	input  wire logic        s_arvalid,
	output logic             s_arready,
	output logic [31:0]      s_rdata,
	output logic [1:0]       s_rresp,
	output logic             s_rvalid,
	input  wire logic        s_rready
);
	// elaboration check: the five bit index serves sixteen entries only
	if (DEPTH != PCS_DEPTH) begin : g_depth_check
		$error("pcs_core: DEPTH must be 16 for a five bit index");
	end

	logic [14:0]         stack_mem [DEPTH];
	logic [PCS_SP_W-1:0] sp_ff;
	logic                ovf_ff;
	logic                unf_ff;
	logic                sre_ff;
	logic [14:0]         pc_inc;
	logic [14:0]         nxt_pc;
	logic                push;
	logic                pop;
	logic                ovf_ev;
	logic                unf_ev;
	logic [PCS_SP_W-1:0] nxt_sp;
	logic [3:0]          slot;
	pcs_ind_type         dec;
	logic                wait_ff;
	logic                aw_ff;
	logic                w_ff;
	logic [7:0]          awaddr_ff;
	logic [31:0]         wdata_ff;
	logic [3:0]          wstrb_ff;
	logic                bus_wr;
	logic                wr_top_lo;
	logic                wr_top_hi;
	logic                wr_index;
	logic                wr_ctl;
	logic                wr_sts;
	logic [31:0]         rd_val;
	logic                rd_ok;

	// ------------------------------------------------------------
	// program counter
	// ------------------------------------------------------------
	assign pc_inc = pc_ff + PCS_PC_ONE;

	always_comb begin
		unique case (op)
			PCS_OP_CALL:   nxt_pc = {page_latch[6:3], operand};
			PCS_OP_CALL_COMPUTED: nxt_pc = {page_latch, acc};
			PCS_OP_ACC_BRANCH: nxt_pc = pc_inc + {7'h00, acc};
			PCS_OP_IMM_JUMP: nxt_pc = pc_inc +
				{{6{operand[8]}}, operand[8:0]};
			PCS_OP_RET:    nxt_pc = stack_mem[slot];
			PCS_OP_PCLWR:  nxt_pc = {page_latch, pc_low_wdata};
			PCS_OP_INT:    nxt_pc = PCS_PC_ONE << 2;
			PCS_OP_NONE:   nxt_pc = ind_stall ? pc_ff : pc_inc;
		endcase
	end

	// pc update; reset or a stack fault clears it
	always_ff @(posedge aclk) begin
		if (!aresetn || stack_fault_reset)
			pc_ff <= PCS_PC_RESET;
		else
			pc_ff <= nxt_pc;
	end

	// ------------------------------------------------------------
	// return stack
	// ------------------------------------------------------------
	assign push   = (op == PCS_OP_CALL) || (op == PCS_OP_CALL_COMPUTED) ||
	                (op == PCS_OP_INT);
	assign pop    = (op == PCS_OP_RET);
	assign nxt_sp = push ? sp_ff + 5'h01 : sp_ff - 5'h01;
	assign ovf_ev = push && (sp_ff == 5'h0F);
	assign unf_ev = pop && (sp_ff == PCS_SP_RESET);
	assign slot   = sp_ff[3:0];
	assign return_pc = stack_mem[slot];
	assign stack_fault_reset = sre_ff && (ovf_ev || unf_ev);

	// stack pointer, writable from the bus; a fault with reset reinits
	always_ff @(posedge aclk) begin
		if (!aresetn || stack_fault_reset)
			sp_ff <= PCS_SP_RESET;
		else if (push)
			sp_ff <= {1'b0, nxt_sp[3:0]};
		else if (pop)
			sp_ff <= (sp_ff == 5'h00) ? PCS_SP_RESET :
				{1'b0, nxt_sp[3:0]};
		else if (wr_index && wstrb_ff[0])
			sp_ff <= wdata_ff[4:0];
	end

	// stack entries: pushed pc or bus writes through the top pair
	always_ff @(posedge aclk) begin
		if (push)
			stack_mem[nxt_sp[3:0]] <= pc_inc;
		else if (wr_top_lo && wstrb_ff[0])
			stack_mem[slot][7:0] <= wdata_ff[7:0];
		else if (wr_top_hi && wstrb_ff[0])
			stack_mem[slot][14:8] <= wdata_ff[6:0];
	end

	// sticky fault flags; hardware set wins over software clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ovf_ff <= 1'b0;
			unf_ff <= 1'b0;
		end else begin
			ovf_ff <= ovf_ev || (ovf_ff &&
				!(wr_sts && wdata_ff[PCS_STS_OVF_BIT]));
			unf_ff <= unf_ev || (unf_ff &&
				!(wr_sts && wdata_ff[PCS_STS_UNF_BIT]));
		end
	end

	// stack reset enable bit, set while the strap is high and no bus write is pending; reset clears it, a control write loads wdata bit 0
	always_ff @(posedge aclk) begin
		if (!aresetn)
			sre_ff <= 1'b0;
		else if (wr_ctl && wstrb_ff[0])
			sre_ff <= wdata_ff[PCS_CTL_SRE_BIT];
		else if (!aw_ff && !w_ff && stack_reset_enable)
			sre_ff <= 1'b1;
	end

	// ------------------------------------------------------------
	// indirect port
	// ------------------------------------------------------------
	pcs_ind_decode i_pcs_ind_decode (
		.pointer (pointer),
		.dec     (dec)
	);

	assign mem_sel   = dec;
	assign ind_stall = ind_req && !ind_we && dec.extra_cycle &&
	                   !wait_ff;
	assign mem_rd    = ind_req && !ind_we;
	assign mem_wr    = ind_req && ind_we && dec.wr_allow;

	// one wait state for eeprom and flash reads
	always_ff @(posedge aclk) begin
		if (!aresetn)
			wait_ff <= 1'b0;
		else
			wait_ff <= ind_stall;
	end

	// read data register
	always_ff @(posedge aclk) begin
		if (!aresetn)
			ind_rdata_ff <= PCS_ZERO_BYTE;
		else if (mem_rd && !ind_stall) begin
			unique case (dec.region)
				PCS_REG_FLASH: ind_rdata_ff <= flash_rdata[7:0];
				PCS_REG_EE:    ind_rdata_ff <= mem_rdata;
				PCS_REG_TRAD:  ind_rdata_ff <= mem_rdata;
				PCS_REG_LIN:   ind_rdata_ff <= mem_implemented ?
					mem_rdata : PCS_ZERO_BYTE;
				PCS_REG_SELF:  ind_rdata_ff <= PCS_ZERO_BYTE;
				default:       ind_rdata_ff <= PCS_ZERO_BYTE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// axi4-lite write channel
	// ------------------------------------------------------------
	assign s_awready = !aw_ff && !s_bvalid;
	assign s_wready  = !w_ff && !s_bvalid;
	assign bus_wr    = aw_ff && w_ff && !s_bvalid;
	assign wr_top_lo = bus_wr && awaddr_ff == PCS_OFS_TOP_LOW;
	assign wr_top_hi = bus_wr && awaddr_ff == PCS_OFS_TOP_HIGH;
	assign wr_index  = bus_wr && awaddr_ff == PCS_OFS_INDEX;
	assign wr_ctl    = bus_wr && awaddr_ff == PCS_OFS_CONTROL;
	assign wr_sts    = bus_wr && awaddr_ff == PCS_OFS_STATUS &&
	                   wstrb_ff[0];

	// address and data capture in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_ff     <= 1'b0;
			w_ff      <= 1'b0;
			awaddr_ff <= 8'h00;
			wdata_ff  <= 32'h0000_0000;
			wstrb_ff  <= 4'h0;
		end else begin
			if (s_awvalid && s_awready) begin
				aw_ff     <= 1'b1;
				awaddr_ff <= s_awaddr;
			end else if (bus_wr)
				aw_ff <= 1'b0;
			if (s_wvalid && s_wready) begin
				w_ff     <= 1'b1;
				wdata_ff <= s_wdata;
				wstrb_ff <= s_wstrb;
			end else if (bus_wr)
				w_ff <= 1'b0;
		end
	end

	// write response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_bvalid <= 1'b0;
			s_bresp  <= PCS_RESP_OKAY;
		end else if (bus_wr) begin
			s_bvalid <= 1'b1;
			s_bresp  <= (awaddr_ff <= PCS_OFS_STATUS) ?
				PCS_RESP_OKAY : PCS_RESP_SLVERR;
		end else if (s_bready)
			s_bvalid <= 1'b0;
	end

	// ------------------------------------------------------------
	// axi4-lite read channel
	// ------------------------------------------------------------
	assign s_arready = !s_rvalid;

	always_comb begin
		rd_val = 32'h0000_0000;
		rd_ok  = 1'b1;
		unique case (s_araddr)
			PCS_OFS_TOP_LOW:  rd_val[7:0]  = return_pc[7:0];
			PCS_OFS_TOP_HIGH: rd_val[6:0]  = return_pc[14:8];
			PCS_OFS_INDEX:    rd_val[4:0]  = sp_ff;
			PCS_OFS_CONTROL:  rd_val[0]    = sre_ff;
			PCS_OFS_STATUS:   rd_val[1:0]  = {unf_ff, ovf_ff};
			PCS_OFS_PC:       rd_val[14:0] = pc_ff;
			PCS_OFS_PAGE:     rd_val[6:0]  = page_latch;
			default:          rd_ok        = 1'b0;
		endcase
	end

	// read data and response registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_rvalid <= 1'b0;
			s_rdata  <= 32'h0000_0000;
			s_rresp  <= PCS_RESP_OKAY;
		end else if (s_arvalid && s_arready) begin
			s_rvalid <= 1'b1;
			s_rdata  <= rd_val;
			s_rresp  <= rd_ok ? PCS_RESP_OKAY : PCS_RESP_SLVERR;
		end else if (s_rready)
			s_rvalid <= 1'b0;
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	call_target_a: assert property (@(posedge aclk) disable iff (!aresetn)
		op == PCS_OP_CALL && !stack_fault_reset |=>
		pc_ff == {$past(page_latch[6:3]), $past(operand)})
		else $error("call target wrong");
	computed_call_a: assert property (@(posedge aclk) disable iff (!aresetn)
		op == PCS_OP_CALL_COMPUTED && !stack_fault_reset |=>
		pc_ff == {$past(page_latch), $past(acc)})
		else $error("computed call target wrong");
	acc_branch_a: assert property (@(posedge aclk) disable iff (!aresetn)
		op == PCS_OP_ACC_BRANCH |=>
		pc_ff == 15'($past(pc_ff) + 15'h0001 + {7'h00, $past(acc)}))
		else $error("acc branch target wrong");
	push_ret_a: assert property (@(posedge aclk) disable iff (!aresetn)
		push && !stack_fault_reset ##1 (op == PCS_OP_NONE && !bus_wr)
		##1 pop |=> pc_ff == 15'($past(pc_ff, 3) + 15'h0001))
		else $error("return address wrong");
	ovf_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
		ovf_ev |=> ovf_ff)
		else $error("overflow flag not set");
	fault_reset_a: assert property (@(posedge aclk) disable iff (!aresetn)
		sre_ff && unf_ev |=> pc_ff == PCS_PC_RESET &&
		sp_ff == PCS_SP_RESET)
		else $error("stack fault did not reset");
	wrap_push_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!sre_ff && push && sp_ff == 5'h0F |=> sp_ff == 5'h00)
		else $error("stack did not wrap");
	self_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
		mem_rd && dec.region == PCS_REG_SELF |=>
		ind_rdata_ff == PCS_ZERO_BYTE)
		else $error("self pointer read not zero");
	ro_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(dec.region == PCS_REG_EE || dec.region == PCS_REG_FLASH) |->
		!mem_wr)
		else $error("write to read only region");
	slow_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
		mem_rd && dec.extra_cycle && !wait_ff |-> ind_stall ##1
		!ind_stall)
		else $error("extra read cycle wrong");

	cov_call_ret_c: cover property (@(posedge aclk) push ##[1:8] pop);
	cov_ovf_c: cover property (@(posedge aclk) ovf_ev);
	cov_ee_c: cover property (@(posedge aclk)
		mem_rd && dec.region == PCS_REG_EE);
	cov_bus_c: cover property (@(posedge aclk) bus_wr && wr_index);
endmodule
`default_nettype wire

// >>> pcs_mem_model.sv
/*
 pcs_mem_model: behavioural data, eeprom and flash memories behind the
 indirect port.
 assumes: driven by the decoded select and read strobe of pcs_core.
*/
`timescale 1ns/1ps
`default_nettype none
module pcs_mem_model
	import pcs_pkg::*;
#(
	parameter int BANKS = 26
)(
	input  wire logic        mem_rd,
	input  wire pcs_ind_type mem_sel,
	output logic [7:0]       mem_rdata,
	output logic [13:0]      flash_rdata,
	output logic             mem_implemented
);
	// ----------------------------------------------------------------
	// memory contents
	// ----------------------------------------------------------------
	logic [15:0] a;
	logic [7:0]  v;
	// pattern per region; inverted data whenever no read is strobed
	always_comb begin
		a = mem_sel.addr;
		case (mem_sel.region)
			PCS_REG_EE:    v = a[7:0] ^ 8'h3C;
			PCS_REG_FLASH: v = a[7:0] ^ 8'hC3;
			default:       v = a[7:0] ^ {a[11:8], a[11:8]};
		endcase
		mem_rdata       = mem_rd ? v : ~v;
		flash_rdata     = mem_rd ? {6'h2A, v} : {6'h15, ~v};
		mem_implemented = (32'(a[11:7]) < BANKS);
	end
endmodule
`default_nettype wire

// >>> pcs_core_bench.sv
/*
 pcs_core_bench: self-checking scenarios for pcs_core.
 assumes: pcs_pkg compiled first; memories come from pcs_mem_model.
*/
`timescale 1ns/1ps
`default_nettype none
module pcs_core_bench;
	import pcs_pkg::*;
	// ----------------------------------------------------------------
	// signals and instances
	// ----------------------------------------------------------------
	localparam logic [1:0] OK = PCS_RESP_OKAY;
	localparam logic [1:0] ER = PCS_RESP_SLVERR;
	localparam logic [6:0] PL = 7'h5A;
	logic        aclk = 1'b0;
	logic        aresetn, stack_reset_enable, stack_fault_reset;
	pcs_op_type  op;
	logic [10:0] operand;
	logic [7:0]  acc, pc_low_wdata, ind_wdata, mem_rdata, ind_rdata_ff;
	logic [6:0]  page_latch;
	logic [14:0] pc_ff, return_pc, ep, bp, ra, rb, rc;
	logic        ind_req, ind_we, ind_stall, mem_rd, mem_wr, mem_implemented;
	logic [15:0] pointer;
	pcs_ind_type mem_sel;
	logic [13:0] flash_rdata;
	logic [7:0]  s_awaddr, s_araddr;
	logic [31:0] s_wdata, s_rdata;
	logic [3:0]  s_wstrb;
	logic [1:0]  s_bresp, s_rresp;
	logic        s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
	logic        s_arvalid, s_arready, s_rvalid, s_rready;
	int          n_mismatch = 0;
	int          samples_checked = 0;

	pcs_core i_pcs_core (.aclk, .aresetn, .op, .operand, .acc, .page_latch,
		.pc_low_wdata, .stack_reset_enable, .pc_ff, .return_pc,
		.stack_fault_reset, .ind_req, .ind_we, .pointer, .ind_wdata,
		.ind_stall, .mem_rd, .mem_wr, .mem_sel, .mem_rdata, .flash_rdata,
		.mem_implemented, .ind_rdata_ff, .s_awaddr, .s_awvalid, .s_awready,
		.s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid,
		.s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp,
		.s_rvalid, .s_rready);
	pcs_mem_model i_pcs_mem_model (.mem_rd, .mem_sel, .mem_rdata,
		.flash_rdata, .mem_implemented);

	// clock at 100 ns
	always #50 aclk = ~aclk;

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task chk(input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask

	task close_out;
		if (n_mismatch == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	function automatic logic [7:0] ftr(input logic [15:0] a);
		return a[7:0] ^ {a[11:8], a[11:8]};
	endfunction

	task do_op(input pcs_op_type o, input logic [10:0] d, input logic [7:0] w);
		@(posedge aclk);
		op <= o;
		operand <= d;
		acc <= w;
		#1;
		bp = pc_ff;
		@(posedge aclk);
		op <= PCS_OP_NONE;
		#1;
	endtask

	task axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		logic pa, pw;
		pa = 1'b1;
		pw = 1'b1;
		@(posedge aclk);
		s_awaddr <= a;
		s_wdata <= d;
		s_awvalid <= 1'b1;
		s_wvalid <= 1'b1;
		s_bready <= 1'b1;
		while (pa | pw) begin
			@(negedge aclk);
			if (s_awready === 1'b1) pa = 1'b0;
			if (s_wready === 1'b1) pw = 1'b0;
			@(posedge aclk);
			s_awvalid <= pa;
			s_wvalid <= pw;
		end
		do @(negedge aclk); while (s_bvalid !== 1'b1);
		chk(32'(s_bresp), 32'(r));
		@(posedge aclk);
		s_bready <= 1'b0;
	endtask

	task axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		@(posedge aclk);
		s_araddr <= a;
		s_arvalid <= 1'b1;
		s_rready <= 1'b1;
		do @(negedge aclk); while (s_arready !== 1'b1);
		@(posedge aclk);
		s_arvalid <= 1'b0;
		do @(negedge aclk); while (s_rvalid !== 1'b1);
		chk(s_rdata, d);
		chk(32'(s_rresp), 32'(r));
		@(posedge aclk);
		s_rready <= 1'b0;
	endtask

	task ind(input logic [15:0] p, input logic we, st, wx, input logic [7:0] d);
		@(posedge aclk);
		pointer <= p;
		ind_we <= we;
		ind_req <= 1'b1;
		ind_wdata <= 8'hE7;
		#1;
		chk(32'(ind_stall), 32'(st));
		if (we) chk(32'(mem_wr), 32'(wx));
		if (ind_stall === 1'b1) @(posedge aclk);
		@(posedge aclk);
		ind_req <= 1'b0;
		ind_we <= 1'b0;
		#1;
		if (!we) chk(32'(ind_rdata_ff), 32'(d));
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task t_reset;
		chk(32'(pc_ff), 32'(PCS_PC_RESET));
		axi_rd(PCS_OFS_INDEX, 32'h1F, OK);
		// pc has advanced one step per idle edge since release
		axi_rd(PCS_OFS_PC, 32'h4, OK);
		axi_rd(8'h20, 32'h0, ER);
		axi_wr(PCS_OFS_PC, 32'h55, ER);
	endtask

	task t_flow;
		do_op(PCS_OP_CALL, 11'h123, 8'h00);
		ra = bp + PCS_PC_ONE;
		ep = {PL[6:3], 11'h123};
		chk(32'(pc_ff), 32'(ep));
		chk(32'(return_pc), 32'(ra));
		axi_rd(PCS_OFS_INDEX, 32'h0, OK);
		do_op(PCS_OP_CALL_COMPUTED, 11'h000, 8'hC3);
		rb = bp + PCS_PC_ONE;
		chk(32'(pc_ff), 32'({PL, 8'hC3}));
		chk(32'(return_pc), 32'(rb));
		axi_rd(PCS_OFS_TOP_LOW, 32'(rb[7:0]), OK);
		axi_rd(PCS_OFS_TOP_HIGH, 32'(rb[14:8]), OK);
		axi_wr(PCS_OFS_INDEX, 32'h0, OK);
		chk(32'(return_pc), 32'(ra));
		axi_rd(PCS_OFS_TOP_LOW, 32'(ra[7:0]), OK);
		axi_wr(PCS_OFS_INDEX, 32'h1, OK);
		do_op(PCS_OP_ACC_BRANCH, 11'h000, 8'hC3);
		ep = bp + PCS_PC_ONE + 15'h00C3;
		chk(32'(pc_ff), 32'(ep));
		do_op(PCS_OP_IMM_JUMP, 11'h1F0, 8'h00);
		ep = bp + PCS_PC_ONE - 15'd16;
		chk(32'(pc_ff), 32'(ep));
		do_op(PCS_OP_PCLWR, 11'h000, 8'h00);
		chk(32'(pc_ff), 32'({PL, 8'h77}));
		do_op(PCS_OP_INT, 11'h000, 8'h00);
		rc = bp + PCS_PC_ONE;
		chk(32'(pc_ff), 32'h4);
		chk(32'(return_pc), 32'(rc));
		do_op(PCS_OP_RET, 11'h000, 8'h00);
		chk(32'(pc_ff), 32'(rc));
		do_op(PCS_OP_RET, 11'h000, 8'h00);
		chk(32'(pc_ff), 32'(rb));
		do_op(PCS_OP_RET, 11'h000, 8'h00);
		chk(32'(pc_ff), 32'(ra));
		axi_rd(PCS_OFS_INDEX, 32'h1F, OK);
	endtask

	task t_ovf;
		for (int i = 0; i < 17; i++) do_op(PCS_OP_CALL, 11'(i), 8'h00);
		ep = bp + PCS_PC_ONE;
		chk(32'(return_pc), 32'(ep));
		axi_rd(PCS_OFS_INDEX, 32'h0, OK);
		axi_rd(PCS_OFS_STATUS, 32'h1, OK);
		axi_wr(PCS_OFS_STATUS, 32'h1, OK);
		axi_wr(PCS_OFS_INDEX, 32'h1F, OK);
		do_op(PCS_OP_RET, 11'h000, 8'h00);
		axi_rd(PCS_OFS_STATUS, 32'h2, OK);
		axi_wr(PCS_OFS_STATUS, 32'h3, OK);
	endtask

	task t_fault;
		@(posedge aclk);
		stack_reset_enable <= 1'b1;
		axi_wr(PCS_OFS_INDEX, 32'h1F, OK);
		axi_rd(PCS_OFS_CONTROL, 32'h1, OK);
		@(posedge aclk);
		op <= PCS_OP_RET;
		#1;
		chk(32'(stack_fault_reset), 32'h1);
		@(posedge aclk);
		op <= PCS_OP_NONE;
		#1;
		chk(32'(pc_ff), 32'h0);
		axi_rd(PCS_OFS_STATUS, 32'h2, OK);
		@(posedge aclk);
		stack_reset_enable <= 1'b0;
	endtask

	task t_ind;
		ind(16'h0123, 0, 0, 0, ftr(16'h0123));
		ind(16'h0001, 0, 0, 0, 8'h00);
		ind(16'h204F, 0, 0, 0, ftr(16'h006F));
		ind(16'h2050, 0, 0, 0, ftr(16'h00A0));
		ind(16'h2960, 0, 0, 0, 8'h00);
		ind(16'h7042, 0, 1, 0, 8'h42 ^ 8'h3C);
		ind(16'h8123, 0, 1, 0, 8'h23 ^ 8'hC3);
		ind(16'h0123, 1, 0, 1, 8'h00);
		ind(16'h7042, 1, 0, 0, 8'h00);
		ind(16'h8123, 1, 0, 0, 8'h00);
		ind(16'h0000, 1, 0, 0, 8'h00);
	endtask

	// main sequence: reset for 16 cycles, then every scenario
	initial begin
		{aresetn, stack_reset_enable, ind_req, ind_we} = 4'h0;
		{s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = 5'h00;
		op = PCS_OP_NONE;
		{operand, acc, pc_low_wdata, ind_wdata, pointer} = 51'h0;
		{s_awaddr, s_araddr, s_wdata} = 48'h0;
		page_latch = PL;
		pc_low_wdata = 8'h77;
		s_wstrb = 4'hF;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset;
		t_flow;
		t_ovf;
		t_fault;
		t_ind;
		close_out;
	end

	// watchdog against a hung handshake
	initial begin
		#(100 * 5000);
		n_mismatch++;
		close_out;
	end
endmodule
`default_nettype wire
